// >>> src/compressor_protection_control.v
// Compressor and indoor fan protection timing controller.
// Assumes all inputs but clk and reset come from pins outside the clock domain; each of
// those passes two flip-flops first. Temperatures are signed, 0.5 degC per count.
`include "cpc_consts.vh"

module compressor_protection_control #(
    parameter TW          = 10,                                  // Temperature width.
    parameter TICK_CYCLES = `TICK_PERIOD_NS / `CLK_PERIOD_NS     // Clocks per 100 ms.
) (
    input  wire                 clk,               // System clock, 200 MHz.
    input  wire                 reset,             // Synchronous reset, active high.
    input  wire                 remote_on,         // Remote on command level.
    input  wire                 remote_off,        // Remote off command level.
    input  wire                 button_off,        // Unit button off level.
    input  wire [1:0]           op_mode,           // Operating mode code.
    input  wire                 quiet_mode,        // Quiet operation selected.
    input  wire                 powerful_mode,     // Powerful operation selected.
    input  wire [2:0]           fan_setting,       // Requested indoor fan speed.
    input  wire signed [TW-1:0] set_temp,          // Remote set temperature.
    input  wire signed [TW-1:0] intake_temp,       // Intake air temperature.
    input  wire signed [TW-1:0] hex_temp,          // Indoor exchanger temperature.
    input  wire signed [TW-1:0] comp_on_temp,      // Compressor on threshold.
    input  wire signed [TW-1:0] comp_off_temp,     // Compressor off threshold.
    output reg                  unit_on_r,         // Unit in operation.
    output reg                  comp_run_r,        // Compressor relay command.
    output reg                  outdoor_fan_r,     // Outdoor fan command.
    output reg                  indoor_fan_r,      // Indoor fan command.
    output reg  [2:0]           fan_speed_r,       // Indoor fan speed command.
    output reg                  dew_active_r,      // Dew prevention active.
    output reg                  freeze_active_r,   // Freeze protection hold.
    output reg  [2:0]           reverse_count_r,   // Reverse rotation stop count.
    output reg                  timer_indicator_r  // Blinking error indicator.
);

    localparam IW = 5 * TW + 10;
    localparam [31:0] TICK_LAST = TICK_CYCLES - 1;
    // Interval loads stay 32 bits wide and are cut on purpose where they meet a timer.
    localparam [31:0] OFF_COOL  = `MIN2TICK(`RESTART_COOL_MIN);
    localparam [31:0] OFF_DRY   = `MIN2TICK(`RESTART_DRY_MIN);
    localparam [31:0] FAN_DLY   = `FAN_DELAY_DSEC;

    // Every input except clk and reset crosses in through two flip-flops; only stage two is read.
    reg  [IW-1:0] sync1_r;
    reg  [IW-1:0] sync2_r;
    wire [IW-1:0] in_raw = {remote_on, remote_off, button_off, op_mode, quiet_mode,
                            powerful_mode, fan_setting, set_temp, intake_temp, hex_temp,
                            comp_on_temp, comp_off_temp};
    always @(posedge clk) begin
        if (reset) begin
            sync1_r <= {IW{1'b0}};
            sync2_r <= {IW{1'b0}};
        end else begin
            sync1_r <= in_raw;
            sync2_r <= sync1_r;
        end
    end

    wire                 on_s    = sync2_r[IW-1];
    wire                 off_s   = sync2_r[IW-2];
    wire                 btn_s   = sync2_r[IW-3];
    wire [1:0]           mode_s  = sync2_r[IW-4:IW-5];
    wire                 quiet_s = sync2_r[IW-6];
    wire                 pwr_s   = sync2_r[IW-7];
    wire [2:0]           fan_s   = sync2_r[IW-8:IW-10];
    wire signed [TW-1:0] set_s   = sync2_r[5*TW-1:4*TW];
    wire signed [TW-1:0] in_s    = sync2_r[4*TW-1:3*TW];
    wire signed [TW-1:0] hex_s   = sync2_r[3*TW-1:2*TW];
    wire signed [TW-1:0] on_t    = sync2_r[2*TW-1:TW];
    wire signed [TW-1:0] off_t   = sync2_r[TW-1:0];

    // Command edges; a held level must not keep re-triggering.
    reg       on_d_r;
    reg       off_d_r;
    reg       btn_d_r;
    reg [1:0] mode_d_r;
    always @(posedge clk) begin
        if (reset) begin
            on_d_r   <= 1'b0;
            off_d_r  <= 1'b0;
            btn_d_r  <= 1'b0;
            mode_d_r <= `MODE_COOL;
        end else begin
            on_d_r   <= on_s;
            off_d_r  <= off_s;
            btn_d_r  <= btn_s;
            mode_d_r <= mode_s;
        end
    end
    wire on_ev    = on_s & ~on_d_r;
    wire off_ev   = (off_s & ~off_d_r) | (btn_s & ~btn_d_r);
    wire mode_chg = mode_s != mode_d_r;

    // One 100 ms tick drives every interval timer; a 1 s tick paces the indicator blinking.
    reg [31:0] div_r;
    reg [3:0]  dsec_r;
    reg        tick_r;
    reg        sec_r;
    always @(posedge clk) begin
        if (reset) begin
            div_r  <= 32'h0;
            dsec_r <= 4'h0;
            tick_r <= 1'b0;
            sec_r  <= 1'b0;
        end else begin
            tick_r <= div_r == TICK_LAST;
            sec_r  <= (div_r == TICK_LAST) && (dsec_r == 4'h9);
            if (div_r == TICK_LAST) begin
                div_r  <= 32'h0;
                dsec_r <= (dsec_r == 4'h9) ? 4'h0 : dsec_r + 4'h1;
            end else begin
                div_r <= div_r + 32'h1;
            end
        end
    end

    // Saturating timer step, advanced only on the tick.
    function [15:0] step;
        input [15:0] t;
        input        run;
        begin
            if (!run)
                step = 16'h0;
            else if (tick_r && t != `TIMER_MAX)
                step = t + 16'h1;
            else
                step = t;
        end
    endfunction

    wire signed [TW:0] gap = in_s - hex_s;

    // Condition timers.
    reg [15:0] run_t_r;
    reg [15:0] off_t_r;
    reg [15:0] cold_t_r;
    reg [15:0] lowdt_t_r;
    reg [15:0] warm_t_r;
    reg [15:0] steady_t_r;
    reg [15:0] win_t_r;
    reg [15:0] min_off_r;
    reg        want_r;
    reg        band_ok_r;

    wire warm_ok    = warm_t_r >= `MIN2TICK(`WARM_MIN);
    wire freeze_hit = comp_run_r && cold_t_r > `MIN2TICK(`FREEZE_MIN);
    wire rev_hit    = comp_run_r && run_t_r >= `MIN2TICK(`REV_RUN_MIN)
                      && lowdt_t_r >= `MIN2TICK(`REV_LOWDT_MIN);
    wire rev_stop   = unit_on_r && !freeze_hit && rev_hit;
    wire rev_trip   = rev_stop && reverse_count_r == `REV_LIMIT - 3'h1;
    wire in_band    = in_s > off_t && in_s < on_t;
    wire thermo_off = in_s <= off_t;
    wire start_ok   = unit_on_r && !freeze_active_r && off_t_r >= min_off_r;
    wire auto_go    = off_t_r >= `MIN2TICK(`AUTO_START_MIN) && band_ok_r;
    wire comp_start = !comp_run_r && start_ok && (want_r || auto_go);

    // Room reference for the steadiness window; a drift restarts it.
    reg signed [TW-1:0] ref_r;
    wire signed [TW:0]  drift = in_s - ref_r;
    wire steady_break = drift > `T_STEADY_BAND || drift < -`T_STEADY_BAND;
    always @(posedge clk) begin
        if (reset)
            ref_r <= {TW{1'b0}};
        else if (!comp_run_r || steady_break)
            ref_r <= in_s;
    end

    // Timers that measure how long a condition has held.
    always @(posedge clk) begin
        if (reset) begin
            run_t_r    <= 16'h0;
            cold_t_r   <= 16'h0;
            lowdt_t_r  <= 16'h0;
            warm_t_r   <= 16'h0;
            steady_t_r <= 16'h0;
            win_t_r    <= 16'h0;
        end else begin
            run_t_r   <= step(run_t_r, comp_run_r);
            cold_t_r  <= step(cold_t_r, comp_run_r && hex_s < `T_FREEZE);
            lowdt_t_r <= step(lowdt_t_r, comp_run_r && gap <= `DT_REVERSE);
            warm_t_r  <= step(warm_t_r, gap > `DT_WARM);
            win_t_r   <= step(win_t_r, reverse_count_r != 3'h0);
            // Room steadiness also needs unbroken compressor running.
            steady_t_r <= step(steady_t_r, comp_run_r && !steady_break);
        end
    end

    // Compressor state. Stop priority: unit off, freeze, reverse, thermo-off.
    always @(posedge clk) begin
        if (reset) begin
            comp_run_r      <= 1'b0;
            outdoor_fan_r   <= 1'b0;
            freeze_active_r <= 1'b0;
            want_r          <= 1'b0;
            band_ok_r       <= 1'b0;
            off_t_r         <= `TIMER_MAX;   // Power up allows an immediate start.
            min_off_r       <= OFF_COOL[15:0];
        end else if (comp_run_r) begin
            off_t_r <= 16'h0;
            if (!unit_on_r) begin
                comp_run_r    <= 1'b0;
                outdoor_fan_r <= 1'b0;
                want_r        <= 1'b0;
                min_off_r     <= OFF_COOL[15:0];
            end else if (freeze_hit) begin
                comp_run_r      <= 1'b0;
                outdoor_fan_r   <= 1'b0;
                freeze_active_r <= 1'b1;
                min_off_r       <= OFF_COOL[15:0];
            end else if (rev_hit) begin
                comp_run_r    <= 1'b0;
                outdoor_fan_r <= 1'b0;
                min_off_r     <= OFF_COOL[15:0];
            end else if (thermo_off && run_t_r >= `SEC2TICK(`MIN_RUN_SEC)) begin
                comp_run_r    <= 1'b0;
                outdoor_fan_r <= 1'b0;
                want_r        <= 1'b0;
                // Soft dry waits longer to let the cycle pressures settle.
                min_off_r <= (mode_s == `MODE_DRY) ? OFF_DRY[15:0]
                                                   : OFF_COOL[15:0];
            end
            band_ok_r <= 1'b1;
        end else begin
            off_t_r <= step(off_t_r, 1'b1);
            if (freeze_active_r && hex_s >= `T_RECOVER)
                freeze_active_r <= 1'b0;
            if (in_s >= on_t)
                want_r <= 1'b1;
            if (!in_band)
                band_ok_r <= 1'b0;
            if (comp_start) begin
                comp_run_r    <= 1'b1;
                outdoor_fan_r <= 1'b1;
                band_ok_r     <= 1'b1;
            end
        end
    end

    // Unit on/off, reverse stop counter and indicator blinking.
    reg blink_r;
    always @(posedge clk) begin
        if (reset) begin
            unit_on_r         <= 1'b0;
            reverse_count_r   <= 3'h0;
            blink_r           <= 1'b0;
            timer_indicator_r <= 1'b0;
        end else begin
            if (off_ev)
                unit_on_r <= 1'b0;
            else if (on_ev)
                unit_on_r <= 1'b1;
            else if (rev_trip)
                unit_on_r <= 1'b0;
            // A stop in the same cycle as a clear still counts.
            if (rev_stop)
                reverse_count_r <= rev_trip ? 3'h0 : reverse_count_r + 3'h1;
            else if (off_ev || warm_ok || mode_chg
                     || win_t_r >= `MIN2TICK(`REV_WINDOW_MIN))
                reverse_count_r <= 3'h0;
            if (rev_trip)
                blink_r <= 1'b1;
            else if (warm_ok)
                blink_r <= 1'b0;
            if (!blink_r)
                timer_indicator_r <= 1'b0;
            else if (sec_r)
                timer_indicator_r <= !timer_indicator_r;
        end
    end

    // Indoor fan: delayed only when it would start with the compressor.
    reg [4:0] fan_dly_r;
    always @(posedge clk) begin
        if (reset) begin
            indoor_fan_r <= 1'b0;
            fan_dly_r    <= 5'h0;
        end else if (!unit_on_r) begin
            indoor_fan_r <= 1'b0;
            fan_dly_r    <= 5'h0;
        end else if (!indoor_fan_r) begin
            if (comp_start)
                fan_dly_r <= FAN_DLY[4:0];
            else if (fan_dly_r == 5'h0)
                indoor_fan_r <= 1'b1;
            else if (tick_r) begin
                fan_dly_r <= fan_dly_r - 5'h1;
                if (fan_dly_r == 5'h1)
                    indoor_fan_r <= 1'b1;
            end
        end
    end

    // Dew prevention and the fan speed it applies.
    wire low_fan   = fan_s == `FAN_CLO || fan_s == `FAN_QLO;
    wire dew_enter = (mode_s == `MODE_COOL || quiet_s) && set_s < `T_DEW_SET && low_fan
                     && steady_t_r >= `MIN2TICK(`STEADY_MIN) && comp_run_r;
    wire dew_leave = set_s > `T_DEW_SET || !low_fan || pwr_s || !unit_on_r;
    reg [15:0] ramp_t_r;
    always @(posedge clk) begin
        if (reset) begin
            dew_active_r <= 1'b0;
            fan_speed_r  <= `FAN_QLO;
            ramp_t_r     <= 16'h0;
        end else begin
            if (dew_leave)
                dew_active_r <= 1'b0;
            else if (dew_enter)
                dew_active_r <= 1'b1;
            ramp_t_r <= step(ramp_t_r, dew_active_r && ramp_t_r < `SEC2TICK(`RAMP_SEC));
            if (!dew_active_r)
                fan_speed_r <= fan_s;
            else if (!(quiet_s && fan_s == `FAN_QLO))
                fan_speed_r <= `FAN_DEW;
            else if (fan_speed_r < `FAN_DEW && ramp_t_r >= `SEC2TICK(`RAMP_SEC)) begin
                // One step a minute keeps quiet operation free of sudden noise.
                fan_speed_r <= fan_speed_r + 3'h1;
                ramp_t_r    <= 16'h0;
            end
        end
    end

endmodule // compressor_protection_control

// >>> src/cpc_consts.vh
// Constants for the compressor protection controller.
// Assumes a 200 MHz clock; temperatures are signed, one count per 0.5 degC.
`ifndef CPC_CONSTS_VH
`define CPC_CONSTS_VH
`define CLK_PERIOD_NS    5
`define TICK_PERIOD_NS   100000000
`define TICKS_PER_SEC    10
`define SEC_PER_MIN      60
`define RESTART_COOL_MIN 3
`define RESTART_DRY_MIN  6
`define AUTO_START_MIN   7
`define MIN_RUN_SEC      60
`define FAN_DELAY_DSEC   16
`define FREEZE_MIN       4
`define REV_RUN_MIN      5
`define REV_LOWDT_MIN    2
`define REV_WINDOW_MIN   50
`define WARM_MIN         1
`define STEADY_MIN       30
`define RAMP_SEC         60
`define MIN2TICK(m)      ((m) * `SEC_PER_MIN * `TICKS_PER_SEC)
`define SEC2TICK(s)      ((s) * `TICKS_PER_SEC)
`define T_FREEZE         10'sh004
`define T_RECOVER        10'sh014
`define DT_REVERSE       11'sh005
`define DT_WARM          11'sh00A
`define T_DEW_SET        10'sh032
`define T_STEADY_BAND    11'sh002
`define REV_LIMIT        3'h5
`define MODE_COOL        2'h0
`define MODE_DRY         2'h1
`define FAN_CLO          3'h1
`define FAN_QLO          3'h0
`define FAN_DEW          3'h3
`define TIMER_MAX        16'hFFFF
`endif

// >>> test/compressor_protection_control_tb.sv
// Self-checking bench for the compressor protection controller.
// Assumes the sensor model and checker files; the tick is shortened to 5 clocks.
`include "cpc_consts.vh"
`define CHK(w, e, g) check(w, 32'(e), 32'(g))
module compressor_protection_control_tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam TW  = 10;
    localparam TK  = 5;
    localparam RUN = `SEC2TICK(`MIN_RUN_SEC) * TK;
    localparam OFF = `MIN2TICK(`RESTART_COOL_MIN) * TK;
    localparam FRZ = `MIN2TICK(`FREEZE_MIN) * TK;
    localparam FAN = `FAN_DELAY_DSEC * TK;
    localparam DRY = `MIN2TICK(`RESTART_DRY_MIN) * TK;
    localparam REV = `MIN2TICK(`REV_RUN_MIN) * TK;
    logic clk = 0, reset = 1, remote_on = 0, remote_off = 0, button_off = 0;
    logic quiet_mode = 0, powerful_mode = 0;
    logic [1:0] op_mode = `MODE_COOL;
    logic [2:0] fan_setting = `FAN_CLO;
    logic signed [TW-1:0] set_temp = 10'h028, comp_on_temp = 10'h034, comp_off_temp = 10'h030;
    logic signed [TW-1:0] intake_set = 10'h03C, hex_set = 10'h028;
    wire signed [TW-1:0] intake_temp, hex_temp;
    wire unit_on_r, comp_run_r, outdoor_fan_r, indoor_fan_r, dew_active_r;
    wire freeze_active_r, timer_indicator_r;
    wire [2:0] fan_speed_r, reverse_count_r;
    int n_fail = 0, samples_checked = 0, n, t0, cyc = 0;
    logic [31:0] rnd = 32'h0000EC77;

    always #2.5 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;

    cpc_sensor_model #(.TW(TW), .SAMPLE(4)) cpc_sensor_model_inst (
        .clk(clk), .intake_set(intake_set), .hex_set(hex_set),
        .intake_temp(intake_temp), .hex_temp(hex_temp));
    compressor_protection_control #(.TW(TW), .TICK_CYCLES(TK)) compressor_protection_control_inst (
        .clk(clk), .reset(reset), .remote_on(remote_on), .remote_off(remote_off),
        .button_off(button_off), .op_mode(op_mode), .quiet_mode(quiet_mode),
        .powerful_mode(powerful_mode), .fan_setting(fan_setting), .set_temp(set_temp),
        .intake_temp(intake_temp), .hex_temp(hex_temp), .comp_on_temp(comp_on_temp),
        .comp_off_temp(comp_off_temp), .unit_on_r(unit_on_r), .comp_run_r(comp_run_r),
        .outdoor_fan_r(outdoor_fan_r), .indoor_fan_r(indoor_fan_r), .fan_speed_r(fan_speed_r),
        .dew_active_r(dew_active_r), .freeze_active_r(freeze_active_r),
        .reverse_count_r(reverse_count_r), .timer_indicator_r(timer_indicator_r));

    // Fixed-seed xorshift, so every run sees the same readings.
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    task automatic roll(input int base, input int span, output logic signed [TW-1:0] v);
        rnd = xs(rnd);
        v = TW'(base + int'(rnd % span));
    endtask
    task automatic check(input string w, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            n_fail++;
            $display("Error %s expected %0h seen %0h", w, e, g);
        end
    endtask
    task automatic span_chk(input string w, input int lo, input int hi, input int g);
        samples_checked++;
        if (g < lo || g > hi) begin
            n_fail++;
            $display("Error %s expected %0d to %0d seen %0d", w, lo, hi, g);
        end
    endtask
    function automatic logic sig(input int s);
        return s == 0 ? unit_on_r : s == 1 ? comp_run_r : indoor_fan_r;
    endfunction
    // Bounded wait on an output level; running out ends the run as a mismatch.
    task automatic await(input int s, input logic v, input int lim);
        n = 0;
        while (sig(s) !== v && n <= lim) begin
            @(negedge clk);
            n++;
        end
        if (n > lim) begin
            n_fail++;
            $display("Error wait %0d expected %0b seen %0b", s, v, sig(s));
            results();
        end
    endtask
    // Commands are levels whose rising edge counts, so each press is a short pulse.
    task automatic pulse(ref logic p);
        p = 1;
        repeat (4) @(negedge clk);
        p = 0;
    endtask
    task automatic results();
        $display("Checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Main sequence: start, minimum run, thermo hold, remote hold, freeze and recovery.
    initial begin
        repeat (20) @(negedge clk);
        reset = 0;
        @(negedge clk);
        `CHK("unit_on", 0, unit_on_r);
        `CHK("comp_run", 0, comp_run_r);
        `CHK("rev_count", 0, reverse_count_r);
        `CHK("indicator", 0, timer_indicator_r);
        $display("Test reset done");
        roll(40, 20, set_temp);
        rnd = xs(rnd);
        fan_setting = rnd[2:0];
        roll(56, 4, intake_set);
        roll(30, 8, hex_set);
        pulse(remote_on);
        await(1, 1, 10);
        t0 = cyc;
        `CHK("fan_held", 0, indoor_fan_r);
        await(2, 1, FAN + 40);
        span_chk("fan_delay", FAN - 12, FAN + 12, cyc - t0);
        `CHK("fan_speed", fan_setting, fan_speed_r);
        `CHK("dew_idle", 0, dew_active_r);
        $display("Test start done");
        roll(44, 4, intake_set);
        await(1, 0, RUN + 400);
        span_chk("min_run", RUN - 2 * TK, RUN + 2 * TK, cyc - t0);
        t0 = cyc;
        roll(56, 4, intake_set);
        await(1, 1, OFF + 400);
        span_chk("thermo_hold", OFF - 2 * TK, OFF + 2 * TK, cyc - t0);
        $display("Test thermo done");
        t0 = cyc;
        pulse(remote_off);
        await(1, 0, 10);
        `CHK("unit_off", 0, unit_on_r);
        repeat (100) @(negedge clk);
        pulse(remote_on);
        await(0, 1, 10);
        await(2, 1, 10);
        `CHK("comp_held", 0, comp_run_r);
        await(1, 1, OFF + 400);
        span_chk("remote_hold", OFF - 2 * TK, OFF + 2 * TK, cyc - t0);
        $display("Test remote done");
        t0 = cyc;
        hex_set = 10'h000;
        await(1, 0, FRZ + 400);
        span_chk("freeze_stop", FRZ, FRZ + 3 * TK, cyc - t0);
        `CHK("freeze_flag", 1, freeze_active_r);
        t0 = cyc;
        hex_set = `T_RECOVER;
        repeat (40) @(negedge clk);
        `CHK("freeze_clear", 0, freeze_active_r);
        `CHK("comp_wait", 0, comp_run_r);
        await(1, 1, OFF + 400);
        span_chk("freeze_hold", OFF - 2 * TK, OFF + 2 * TK, cyc - t0);
        $display("Test freeze done");
        op_mode = `MODE_DRY;
        roll(44, 4, intake_set);
        await(1, 0, RUN + 400);
        t0 = cyc;
        roll(56, 4, intake_set);
        await(1, 1, DRY + 400);
        span_chk("dry_hold", DRY - 2 * TK, DRY + 2 * TK, cyc - t0);
        $display("Test dry done");
        t0 = cyc;
        hex_set = intake_set - 10'sh004;
        await(1, 0, REV + 400);
        span_chk("rev_stop", REV - 2 * TK, REV + 2 * TK, cyc - t0);
        `CHK("rev_count", 1, reverse_count_r);
        t0 = cyc;
        await(1, 1, OFF + 400);
        span_chk("rev_hold", OFF - 2 * TK, OFF + 2 * TK, cyc - t0);
        $display("Test reverse done");
        pulse(button_off);
        await(0, 0, 10);
        repeat (2) @(negedge clk);
        `CHK("button_stop", 0, comp_run_r);
        `CHK("count_clear", 0, reverse_count_r);
        $display("Test button done");
        results();
    end
endmodule // compressor_protection_control_tb

bind compressor_protection_control cpc_checker #(.TW(TW), .TICK_CYCLES(TICK_CYCLES)) cpc_checker_inst (
    .clk(clk), .reset(reset), .powerful_mode(powerful_mode), .hex_temp(hex_temp),
    .unit_on_r(unit_on_r), .comp_run_r(comp_run_r), .outdoor_fan_r(outdoor_fan_r),
    .indoor_fan_r(indoor_fan_r), .dew_active_r(dew_active_r),
    .freeze_active_r(freeze_active_r), .reverse_count_r(reverse_count_r));

// >>> test/cpc_checker_chk.sv
// Concurrent checks on the ports of the compressor protection controller.
// Assumes binding to the top module with its synchronous active-high reset.
`include "cpc_consts.vh"
module cpc_checker #(
    parameter TW          = 10,   // Temperature width.
    parameter TICK_CYCLES = 10    // Clocks per tick.
) (
    input wire logic                 clk,              // System clock.
    input wire logic                 reset,            // Synchronous reset.
    input wire logic                 powerful_mode,    // Powerful selected.
    input wire logic signed [TW-1:0] hex_temp,         // Exchanger reading.
    input wire logic                 unit_on_r,        // Unit in operation.
    input wire logic                 comp_run_r,       // Compressor command.
    input wire logic                 outdoor_fan_r,    // Outdoor fan command.
    input wire logic                 indoor_fan_r,     // Indoor fan command.
    input wire logic                 dew_active_r,     // Dew prevention.
    input wire logic                 freeze_active_r,  // Freeze hold.
    input wire logic [2:0]           reverse_count_r   // Reverse stop count.
);
    timeunit 1ns;
    timeprecision 100ps;
    // One tick of slack, since the tick runs free of the events it times.
    localparam int MIN_RUN = (`SEC2TICK(`MIN_RUN_SEC) - 1) * TICK_CYCLES;
    localparam int MIN_OFF = (`MIN2TICK(`RESTART_COOL_MIN) - 1) * TICK_CYCLES;
    localparam int FRZ     = (`MIN2TICK(`FREEZE_MIN) - 1) * TICK_CYCLES;
    logic [31:0] run_r;
    logic [31:0] off_r;
    logic [31:0] cold_r;
    logic        stopped_r;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    // Streak lengths; stopped_r keeps the saturated off timer after reset out of view.
    always @(posedge clk) begin
        if (reset) begin
            run_r     <= 32'h0;
            off_r     <= 32'h0;
            cold_r    <= 32'h0;
            stopped_r <= 1'b0;
        end else begin
            run_r     <= comp_run_r ? run_r + 32'h1 : 32'h0;
            off_r     <= comp_run_r ? 32'h0 : off_r + 32'h1;
            cold_r    <= (hex_temp < `T_FREEZE) ? cold_r + 32'h1 : 32'h0;
            stopped_r <= stopped_r | $fell(comp_run_r);
        end
    end

    property p_reset_clear;
        $fell(reset) |-> !unit_on_r && !comp_run_r && !freeze_active_r && reverse_count_r == 3'h0;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("outputs not clear");
    property p_off_stop;
        $fell(unit_on_r) |=> !comp_run_r;
    endproperty
    a_off_stop: assert property (p_off_stop) else $error("compressor kept on");
    property p_fan_pair;
        outdoor_fan_r == comp_run_r;
    endproperty
    a_fan_pair: assert property (p_fan_pair) else $error("outdoor fan apart");
    property p_fan_delay;
        $rose(comp_run_r) && !indoor_fan_r |=> !indoor_fan_r [*8];
    endproperty
    a_fan_delay: assert property (p_fan_delay) else $error("indoor fan early");
    property p_min_run;
        $fell(comp_run_r) && $past(unit_on_r) |-> run_r >= MIN_RUN;
    endproperty
    a_min_run: assert property (p_min_run) else $error("run too short");
    property p_min_off;
        $rose(comp_run_r) && stopped_r |-> off_r >= MIN_OFF;
    endproperty
    a_min_off: assert property (p_min_off) else $error("off too short");
    property p_freeze_hold;
        freeze_active_r |-> !$rose(comp_run_r);
    endproperty
    a_freeze_hold: assert property (p_freeze_hold) else $error("start in freeze");
    property p_freeze_entry;
        $rose(freeze_active_r) |-> cold_r >= FRZ;
    endproperty
    a_freeze_entry: assert property (p_freeze_entry) else $error("freeze early");
    property p_rev_limit;
        reverse_count_r < `REV_LIMIT;
    endproperty
    a_rev_limit: assert property (p_rev_limit) else $error("count past limit");
    property p_dew_run;
        $rose(dew_active_r) |-> $past(comp_run_r);
    endproperty
    a_dew_run: assert property (p_dew_run) else $error("dew while stopped");
    property p_dew_exit;
        dew_active_r && powerful_mode |-> ##[1:6] !dew_active_r;
    endproperty
    a_dew_exit: assert property (p_dew_exit) else $error("dew kept");

    // Main scenarios: thermo stop, freeze stop, guarded restart.
    c_thermo: cover property ($fell(comp_run_r) && unit_on_r);
    c_freeze: cover property ($rose(freeze_active_r));
    c_restart: cover property ($rose(comp_run_r) && stopped_r);
endmodule // cpc_checker

// >>> test/cpc_sensor_model.sv
// Sensor front end standing in for the intake and exchanger probes.
// Assumes the bench sets target readings; a new reading lands every SAMPLE clocks.
module cpc_sensor_model #(
    parameter TW     = 10,   // Temperature width.
    parameter SAMPLE = 4     // Clocks between readings.
) (
    input  wire logic                 clk,          // System clock.
    input  wire logic signed [TW-1:0] intake_set,   // Target intake reading.
    input  wire logic signed [TW-1:0] hex_set,      // Target exchanger reading.
    output logic signed      [TW-1:0] intake_temp,  // Intake probe reading.
    output logic signed      [TW-1:0] hex_temp      // Exchanger probe reading.
);
    timeunit 1ns;
    timeprecision 100ps;
    int cnt = 0;

    // Readings change on the falling edge, so the block never sees a change on the edge it is made.
    always @(negedge clk) begin
        cnt = (cnt + 1) % SAMPLE;
        if (cnt == 0) begin
            intake_temp <= intake_set;
            hex_temp    <= hex_set;
        end
    end
endmodule // cpc_sensor_model
